// File: elcb_bank.sv
// exposure loop config bank with serial configuration port
// Functional notes
// - four 2-bit upper pattern fields, used only while pattern insertion is on
// - freeze bit 2 stops loop filter updates and holds enforcer gains
// - subsample bit 3: 0 every pixel, 1 every fourth pixel
// - priority bit 4: 1 gives stage one priority; resets to 1
// - four 10-bit 3.7 colour weights, each resetting to 0x80
// - lower 8 pattern bits per lane join the upper field
// - read-only bit 12 reports loop filter lock
`timescale 1ns/1ps
module elcb_bank (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // serial configuration port
  input wire logic spi_clk,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  output logic spi_miso,
  // loop status in
  input wire logic loop_locked,
  // settings out
  output logic [3:0][9:0] lane_pattern,
  output elcb_pkg::elcb_loop_cfg_t loop_cfg
);

  elcb_pkg::elcb_state_t s_q;
  elcb_pkg::elcb_state_t s_d;

  // read data for an address; unmapped and spare words read zero
  function automatic logic [15:0] rd_word(input elcb_pkg::elcb_state_t s, input logic [8:0] a);
    logic [15:0] r;
    r = 16'h0000;
    case (a)
      elcb_pkg::ADDR_TEST_CONFIG: r = {15'h0000, s.pat_en};
      elcb_pkg::ADDR_LOWER_01: r = s.lower01;
      elcb_pkg::ADDR_LOWER_23: r = s.lower23;
      elcb_pkg::ADDR_UPPER: r = {8'h00, s.upper};
      elcb_pkg::ADDR_LOOP_CTRL: r = {11'h000, s.ctrl};
      elcb_pkg::ADDR_TARGET: r = s.target;
      elcb_pkg::ADDR_WEIGHT_RED: r = {6'h00, s.weight[0]};
      elcb_pkg::ADDR_WEIGHT_G1: r = {6'h00, s.weight[1]};
      elcb_pkg::ADDR_WEIGHT_G2: r = {6'h00, s.weight[2]};
      elcb_pkg::ADDR_WEIGHT_BLUE: r = {6'h00, s.weight[3]};
      elcb_pkg::ADDR_LOOP_STATUS: r[elcb_pkg::STATUS_LOCKED] = s.locked;
      default: r = 16'h0000;
    endcase
    return r;
  endfunction

  // 10-bit lane pattern, zero while insertion is off
  function automatic logic [9:0] lane_value(input logic en, input logic [1:0] up,
                                            input logic [7:0] lo);
    return en ? {up, lo} : 10'h000;
  endfunction

  // next state: serial shifting, register writes, derived outputs
  always_comb begin
    logic rise;
    logic fall;
    logic [15:0] wdata;
    rise = 1'b0;
    fall = 1'b0;
    wdata = 16'h0000;
    s_d = s_q;
    s_d.sck_prev = spi_clk;
    s_d.locked = loop_locked;
    rise = spi_clk && !s_q.sck_prev;
    fall = !spi_clk && s_q.sck_prev;
    if (spi_cs_n) begin
      s_d.cnt = 5'd0;
      s_d.miso = 1'b0;
    end else if (rise) begin
      s_d.sh = {s_q.sh[23:0], spi_mosi};
      s_d.cnt = s_q.cnt + 5'd1;
      if (s_q.cnt == elcb_pkg::FRAME_HDR_LAST) begin
        s_d.addr = s_q.sh[8:0];
        s_d.wr = spi_mosi;
        s_d.rd_sh = rd_word(s_q, s_q.sh[8:0]);
      end
      if (s_q.cnt == elcb_pkg::FRAME_LAST) begin
        s_d.cnt = 5'd0;
        wdata = {s_q.sh[14:0], spi_mosi};
        if (s_q.wr) begin
          case (s_q.addr)
            elcb_pkg::ADDR_TEST_CONFIG: s_d.pat_en = wdata[0];
            elcb_pkg::ADDR_LOWER_01: s_d.lower01 = wdata;
            elcb_pkg::ADDR_LOWER_23: s_d.lower23 = wdata;
            elcb_pkg::ADDR_UPPER: s_d.upper = wdata[7:0];
            elcb_pkg::ADDR_LOOP_CTRL: s_d.ctrl = wdata[4:0];
            elcb_pkg::ADDR_TARGET: s_d.target = wdata;
            elcb_pkg::ADDR_WEIGHT_RED: s_d.weight[0] = wdata[9:0];
            elcb_pkg::ADDR_WEIGHT_G1: s_d.weight[1] = wdata[9:0];
            elcb_pkg::ADDR_WEIGHT_G2: s_d.weight[2] = wdata[9:0];
            elcb_pkg::ADDR_WEIGHT_BLUE: s_d.weight[3] = wdata[9:0];
            default: s_d.pat_en = s_q.pat_en;
          endcase
        end
      end
    end else if (fall && s_q.cnt > elcb_pkg::FRAME_HDR_LAST) begin
      s_d.miso = s_q.rd_sh[15];
      s_d.rd_sh = {s_q.rd_sh[14:0], 1'b0};
    end
    // lane patterns from upper and lower fields
    s_d.lane_pat[0] = lane_value(s_q.pat_en, s_q.upper[1:0], s_q.lower01[7:0]);
    s_d.lane_pat[1] = lane_value(s_q.pat_en, s_q.upper[3:2], s_q.lower01[15:8]);
    s_d.lane_pat[2] = lane_value(s_q.pat_en, s_q.upper[5:4], s_q.lower23[7:0]);
    s_d.lane_pat[3] = lane_value(s_q.pat_en, s_q.upper[7:6], s_q.lower23[15:8]);
    // loop settings
    s_d.cfg.run = s_q.ctrl[elcb_pkg::CTRL_ENABLE];
    s_d.cfg.restart = s_q.ctrl[elcb_pkg::CTRL_RESTART];
    s_d.cfg.freeze = s_q.ctrl[elcb_pkg::CTRL_FREEZE];
    s_d.cfg.subsample = s_q.ctrl[elcb_pkg::CTRL_SUBSAMPLE];
    s_d.cfg.stage1_first = s_q.ctrl[elcb_pkg::CTRL_STAGE1_FIRST];
    s_d.cfg.target = s_q.target[9:0];
    s_d.cfg.weight = s_q.weight;
  end

  // state register
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      s_q <= '0;
      s_q.lower01 <= elcb_pkg::RST_LOWER_01;
      s_q.lower23 <= elcb_pkg::RST_LOWER_23;
      s_q.upper <= elcb_pkg::RST_UPPER;
      s_q.ctrl <= elcb_pkg::RST_LOOP_CTRL;
      s_q.target <= elcb_pkg::RST_TARGET;
      s_q.weight <= {4{elcb_pkg::RST_WEIGHT}};
      s_q.cfg.stage1_first <= elcb_pkg::RST_LOOP_CTRL[elcb_pkg::CTRL_STAGE1_FIRST];
      s_q.cfg.target <= elcb_pkg::RST_TARGET[9:0];
      s_q.cfg.weight <= {4{elcb_pkg::RST_WEIGHT}};
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from flops
  assign spi_miso = s_q.miso;
  assign lane_pattern = s_q.lane_pat;
  assign loop_cfg = s_q.cfg;

  // checks
  property p_lane_off;
    @(posedge core_clk) disable iff (!resetn)
      !s_q.pat_en |=> lane_pattern == '0;
  endproperty
  a_lane_off: assert property (p_lane_off) else $error("lane pattern while disabled");

  property p_lane_join;
    @(posedge core_clk) disable iff (!resetn)
      s_q.pat_en |=> lane_pattern[3] == {$past(s_q.upper[7:6]), $past(s_q.lower23[15:8])};
  endproperty
  a_lane_join: assert property (p_lane_join) else $error("lane 3 pattern wrong");

  property p_freeze;
    @(posedge core_clk) disable iff (!resetn)
      s_q.ctrl[2] |=> loop_cfg.freeze;
  endproperty
  a_freeze: assert property (p_freeze) else $error("freeze not passed on");

  property p_subsample;
    @(posedge core_clk) disable iff (!resetn)
      ##1 loop_cfg.subsample == $past(s_q.ctrl[3]);
  endproperty
  a_subsample: assert property (p_subsample) else $error("subsample select wrong");

  property p_prio_reset;
    @(posedge core_clk) $rose(resetn) |-> loop_cfg.stage1_first && s_q.ctrl[4];
  endproperty
  a_prio_reset: assert property (p_prio_reset) else $error("priority not 1 after reset");

  property p_weight_reset;
    @(posedge core_clk) $rose(resetn) |->
      loop_cfg.weight[0] == elcb_pkg::RST_WEIGHT && s_q.weight[3] == elcb_pkg::RST_WEIGHT;
  endproperty
  a_weight_reset: assert property (p_weight_reset) else $error("weight reset wrong");

  sequence s_lock_change;
    $changed(loop_locked);
  endsequence
  property p_lock;
    @(posedge core_clk) disable iff (!resetn)
      s_lock_change |=> s_q.locked == $past(loop_locked);
  endproperty
  a_lock: assert property (p_lock) else $error("lock status not tracked");

  property p_run;
    @(posedge core_clk) disable iff (!resetn)
      $rose(s_q.ctrl[0]) |=> loop_cfg.run ##0 loop_cfg.target == $past(s_q.target[9:0]);
  endproperty
  a_run: assert property (p_run) else $error("enable not passed on");

  // restart level follows control bit 1 one edge later
  property p_restart;
    @(posedge core_clk) disable iff (!resetn)
      ##1 loop_cfg.restart == $past(s_q.ctrl[elcb_pkg::CTRL_RESTART]);
  endproperty
  a_restart: assert property (p_restart) else $error("restart not passed on");

  // stage priority follows control bit 4 one edge later
  property p_prio_pass;
    @(posedge core_clk) disable iff (!resetn)
      ##1 loop_cfg.stage1_first == $past(s_q.ctrl[elcb_pkg::CTRL_STAGE1_FIRST]);
  endproperty
  a_prio_pass: assert property (p_prio_pass) else $error("priority not passed on");

  // all four colour weights reach the loop one edge later
  property p_weight_pass;
    @(posedge core_clk) disable iff (!resetn)
      ##1 loop_cfg.weight == $past(s_q.weight);
  endproperty
  a_weight_pass: assert property (p_weight_pass) else $error("weights not passed on");

  // lane 0 joins its upper field with the low byte of the first lower word
  property p_lane0_join;
    @(posedge core_clk) disable iff (!resetn)
      s_q.pat_en |=> lane_pattern[0] == {$past(s_q.upper[1:0]), $past(s_q.lower01[7:0])};
  endproperty
  a_lane0_join: assert property (p_lane0_join) else $error("lane 0 pattern wrong");

  // target intensity comes back to its reset value after every reset
  property p_target_reset;
    @(posedge core_clk) $rose(resetn) |-> loop_cfg.target == elcb_pkg::RST_TARGET[9:0];
  endproperty
  a_target_reset: assert property (p_target_reset) else $error("target reset wrong");

  // status read: lock bit is loaded into the read shifter at the header's last bit
  sequence s_hdr_last;
    !spi_cs_n && spi_clk && !s_q.sck_prev && s_q.cnt == elcb_pkg::FRAME_HDR_LAST;
  endsequence
  sequence s_status_addr;
    s_q.sh[8:0] == elcb_pkg::ADDR_LOOP_STATUS;
  endsequence
  property p_status_load;
    @(posedge core_clk) disable iff (!resetn)
      s_hdr_last ##0 s_status_addr |=> s_q.rd_sh[elcb_pkg::STATUS_LOCKED] == $past(s_q.locked);
  endproperty
  a_status_load: assert property (p_status_load) else $error("lock bit not loaded");
endmodule

// File: elcb_host.sv
// host model driving the serial configuration port of the bank
`timescale 1ns/1ps
module elcb_host (
  // clock
  input wire logic core_clk,
  // serial port
  output logic spi_clk,
  output logic spi_cs_n,
  output logic spi_mosi,
  input wire logic spi_miso
);
  // idle: clock stands low, frame deselected
  initial begin
    spi_clk = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
  end
  // one frame: address msb first, write flag, data msb first
  task automatic xfer(input logic [8:0] a, input logic w, input logic [15:0] d,
                      output logic [15:0] q);
    logic [25:0] fr;
    fr = {a, w, d};
    q = 16'h0000;
    @(posedge core_clk) #1 spi_cs_n = 1'b0;
    for (int i = 25; i >= 0; i--) begin
      spi_mosi = fr[i];
      spi_clk = 1'b0;
      repeat (2) @(posedge core_clk);
      #1 spi_clk = 1'b1;
      repeat (2) @(posedge core_clk);
      #1 if (i < 16) q[i] = spi_miso;
    end
    spi_clk = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = ~spi_mosi; // released line shows no stale bit
    @(posedge core_clk);
  endtask
endmodule

// File: elcb_pkg.sv
// register map, reset values, field positions and types of the exposure loop config bank
package elcb_pkg;
  // register addresses on the serial configuration port
  localparam logic [8:0] ADDR_TEST_CONFIG = 9'h090;
  localparam logic [8:0] ADDR_LOWER_01 = 9'h092;
  localparam logic [8:0] ADDR_LOWER_23 = 9'h093;
  localparam logic [8:0] ADDR_UPPER = 9'h096;
  localparam logic [8:0] ADDR_SPARE_A = 9'h09a;
  localparam logic [8:0] ADDR_SPARE_B = 9'h09b;
  localparam logic [8:0] ADDR_LOOP_CTRL = 9'h0a0;
  localparam logic [8:0] ADDR_TARGET = 9'h0a1;
  localparam logic [8:0] ADDR_WEIGHT_RED = 9'h0a2;
  localparam logic [8:0] ADDR_WEIGHT_G1 = 9'h0a3;
  localparam logic [8:0] ADDR_WEIGHT_G2 = 9'h0a4;
  localparam logic [8:0] ADDR_WEIGHT_BLUE = 9'h0a5;
  localparam logic [8:0] ADDR_LOOP_STATUS = 9'h0ba;
  // reset values
  localparam logic [15:0] RST_LOWER_01 = 16'h0100;
  localparam logic [15:0] RST_LOWER_23 = 16'h0302;
  localparam logic [7:0] RST_UPPER = 8'h00;
  localparam logic [4:0] RST_LOOP_CTRL = 5'h10;
  localparam logic [15:0] RST_TARGET = 16'h60b8;
  localparam logic [9:0] RST_WEIGHT = 10'h080;
  // field positions
  localparam int CTRL_ENABLE = 0;
  localparam int CTRL_RESTART = 1;
  localparam int CTRL_FREEZE = 2;
  localparam int CTRL_SUBSAMPLE = 3;
  localparam int CTRL_STAGE1_FIRST = 4;
  localparam int STATUS_LOCKED = 12;
  // serial frame: 9 address bits, write flag, 16 data bits
  localparam logic [4:0] FRAME_HDR_LAST = 5'd9;
  localparam logic [4:0] FRAME_LAST = 5'd25;

  // settings handed to the exposure loop
  typedef struct packed {
    logic run;
    logic restart;
    logic freeze;
    logic subsample;
    logic stage1_first;
    logic [9:0] target;
    logic [3:0][9:0] weight; // 0 red, 1 first green, 2 second green, 3 blue
  } elcb_loop_cfg_t;

  // whole state of the bank
  typedef struct packed {
    logic sck_prev;
    logic [4:0] cnt;
    logic [24:0] sh;
    logic wr;
    logic [8:0] addr;
    logic [15:0] rd_sh;
    logic miso;
    logic pat_en;
    logic [15:0] lower01;
    logic [15:0] lower23;
    logic [7:0] upper;
    logic [4:0] ctrl;
    logic [15:0] target;
    logic [3:0][9:0] weight;
    logic locked;
    logic [3:0][9:0] lane_pat;
    elcb_loop_cfg_t cfg;
  } elcb_state_t;
endpackage

// File: tb.sv
// self-checking testbench of the exposure loop config bank
`timescale 1ns/1ps
module tb;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic loop_locked = 1'b0;
  logic spi_clk;
  logic spi_cs_n;
  logic spi_mosi;
  logic spi_miso;
  logic [3:0][9:0] lane_pattern;
  elcb_pkg::elcb_loop_cfg_t loop_cfg;
  logic [15:0] rd;
  int fails = 0;
  int checked = 0;
  // 100 MHz clock
  always #5 core_clk = ~core_clk;
  elcb_host u_host (.core_clk(core_clk), .spi_clk(spi_clk), .spi_cs_n(spi_cs_n),
    .spi_mosi(spi_mosi), .spi_miso(spi_miso));
  elcb_bank u_dut (.core_clk(core_clk), .resetn(resetn), .spi_clk(spi_clk),
    .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
    .loop_locked(loop_locked), .lane_pattern(lane_pattern), .loop_cfg(loop_cfg));
  // compare and report
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // control levels on the loop settings, packed as they sit in the control word
  function automatic logic [15:0] ctl_seen();
    return {11'h000, loop_cfg.stage1_first, loop_cfg.subsample, loop_cfg.freeze,
      loop_cfg.restart, loop_cfg.run};
  endfunction
  task automatic wr(input logic [8:0] a, input logic [15:0] d);
    u_host.xfer(a, 1'b1, d, rd);
    repeat (2) @(posedge core_clk);
  endtask
  task automatic rdc(input string what, input logic [8:0] a, input logic [15:0] e);
    u_host.xfer(a, 1'b0, 16'h0000, rd);
    chk(what, rd, e);
  endtask
  task automatic tally_and_finish;
    if (fails == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // values left by reset
  task automatic t_reset;
    chk("ctl", ctl_seen(), 16'h0010);
    chk("tgt", 16'(loop_cfg.target), 16'h00b8);
    for (int i = 0; i < 4; i++) chk("wt", 16'(loop_cfg.weight[i]), 16'h0080);
    chk("pat", 16'(lane_pattern[1]), 16'h0000);
    rdc("ctl_rd", elcb_pkg::ADDR_LOOP_CTRL, 16'h0010);
    rdc("tgt_rd", elcb_pkg::ADDR_TARGET, 16'h60b8);
    rdc("wt_rd", elcb_pkg::ADDR_WEIGHT_BLUE, 16'h0080);
  endtask
  // each control bit alone, then target
  task automatic t_ctrl;
    for (int b = 0; b < 5; b++) begin
      wr(elcb_pkg::ADDR_LOOP_CTRL, 16'h0001 << b);
      chk("ctl", ctl_seen(), 16'h0001 << b);
    end
    wr(elcb_pkg::ADDR_TARGET, 16'h0123);
    chk("tgt", 16'(loop_cfg.target), 16'h0123);
    rdc("ctl_rd", elcb_pkg::ADDR_LOOP_CTRL, 16'h0010);
    rdc("tgt_rd", elcb_pkg::ADDR_TARGET, 16'h0123);
  endtask
  // four distinct colour weights
  task automatic t_weights;
    for (int i = 0; i < 4; i++) wr(elcb_pkg::ADDR_WEIGHT_RED + 9'(i), 16'h03ff - 16'(i));
    for (int i = 0; i < 4; i++) chk("wt", 16'(loop_cfg.weight[i]), 16'h03ff - 16'(i));
    rdc("wt_rd", elcb_pkg::ADDR_WEIGHT_G2, 16'h03fd);
  endtask
  // lane patterns gated by the enable, upper joined with lower
  task automatic t_pattern;
    wr(elcb_pkg::ADDR_UPPER, 16'h00e4);
    chk("pat_off", 16'(lane_pattern[3]), 16'h0000);
    wr(elcb_pkg::ADDR_TEST_CONFIG, 16'h0001);
    for (int i = 0; i < 4; i++) chk("pat", 16'(lane_pattern[i]), 16'(i * 257));
    wr(elcb_pkg::ADDR_LOWER_01, 16'h55aa);
    chk("pat0", 16'(lane_pattern[0]), 16'h00aa);
    chk("pat1", 16'(lane_pattern[1]), 16'h0155);
    wr(elcb_pkg::ADDR_LOWER_23, 16'h9966);
    chk("pat2", 16'(lane_pattern[2]), 16'h0266);
    chk("pat3", 16'(lane_pattern[3]), 16'h0399);
    rdc("up_rd", elcb_pkg::ADDR_UPPER, 16'h00e4);
    rdc("lo_rd", elcb_pkg::ADDR_LOWER_23, 16'h9966);
    rdc("en_rd", elcb_pkg::ADDR_TEST_CONFIG, 16'h0001);
    wr(elcb_pkg::ADDR_TEST_CONFIG, 16'h0000);
    chk("pat_off", 16'(lane_pattern[2]), 16'h0000);
  endtask
  // lock status is read only, spare word A ignores writes
  task automatic t_status;
    #1 loop_locked = 1'b1;
    rdc("lock", elcb_pkg::ADDR_LOOP_STATUS, 16'h1000);
    wr(elcb_pkg::ADDR_LOOP_STATUS, 16'h0000);
    rdc("lock_ro", elcb_pkg::ADDR_LOOP_STATUS, 16'h1000);
    #1 loop_locked = 1'b0;
    rdc("unlock", elcb_pkg::ADDR_LOOP_STATUS, 16'h0000);
    wr(elcb_pkg::ADDR_SPARE_A, 16'hffff);
    rdc("spare", elcb_pkg::ADDR_SPARE_A, 16'h0000);
  endtask
  // reset in mid-run brings every setting back to its reset value
  task automatic t_midreset;
    wr(elcb_pkg::ADDR_LOOP_CTRL, 16'h000f);
    chk("ctl_pre", ctl_seen(), 16'h000f);
    #1 resetn = 1'b0;
    repeat (2) @(posedge core_clk);
    #1 resetn = 1'b1;
    chk("ctl_rst", ctl_seen(), 16'h0010);
    chk("tgt_rst", 16'(loop_cfg.target), 16'h00b8);
    for (int i = 0; i < 4; i++) chk("wt_rst", 16'(loop_cfg.weight[i]), 16'h0080);
    rdc("lo_rst", elcb_pkg::ADDR_LOWER_01, 16'h0100);
    wr(elcb_pkg::ADDR_TEST_CONFIG, 16'h0001);
    chk("pat_rst", 16'(lane_pattern[1]), 16'h0001);
  endtask
  // watchdog against a hang
  initial begin
    #200000;
    fails++;
    tally_and_finish();
  end
  // main sequence
  initial begin
    repeat (4) @(posedge core_clk);
    #1 resetn = 1'b1;
    t_reset();
    t_ctrl();
    t_weights();
    t_pattern();
    t_status();
    t_midreset();
    tally_and_finish();
  end
endmodule
